// *** hdl/vcs_defines.svh ***
/*
  Offsets, field positions, fixed values and reset values of the VC0 status
  and VC1 capability registers.
  Assumes inclusion by bare name from the design files.
*/
`ifndef VCS_DEFINES_SVH
`define VCS_DEFINES_SVH

// Extended configuration byte offsets
`define VCS_ADDR_W 12
`define VCS_OFF_VC0_STATUS 12'h16a
`define VCS_OFF_VC1_CAP 12'h16c

// Status register layout
`define VCS_STAT_W 16
`define VCS_STAT_RESET 16'h0000
`define VCS_STAT_PEND_BIT 1
`define VCS_STAT_TBL_BIT 0

// Capability register field values
`define VCS_CAP_TBL_LOC 8'h07
`define VCS_CAP_SLOTS 7'h7f
`define VCS_CAP_SNOOP_REJ 1'h0
`define VCS_CAP_AS_ONLY 1'h0
`define VCS_CAP_SCHEMES 8'h11
`define VCS_CAP_RESET 32'h077f0011

// Scheme bit positions inside the capability field
`define VCS_SCH_FIXED_RR 0
`define VCS_SCH_WRR32 1
`define VCS_SCH_WRR64 2
`define VCS_SCH_WRR128 3
`define VCS_SCH_TB_WRR128 4
`define VCS_SCH_WRR256 5

// Bus data width and idle values
`define VCS_DATA_W 32
`define VCS_DATA_ZERO 32'h00000000

`endif

// *** hdl/vcs_pkg.sv ***
/*
  Types shared by the VC status and capability register block.
  Includes the defines header itself for the data width.
*/
`include "vcs_defines.svh"

package vcs_pkg;

  // Table refresh sequencing
  typedef enum logic [1:0] {
    VCS_TBL_IDLE = 2'b00,
    VCS_TBL_LOAD = 2'b01
  } vcs_tbl_state_t;

  // State of the table tracker
  typedef struct packed {
    vcs_tbl_state_t state;
    logic changed;
    logic dirty_in_load;
    logic copy_req;
  } vcs_tbl_regs_t;

  // State of the top block
  typedef struct packed {
    logic [`VCS_DATA_W-1:0] rdata;
    logic rd_valid;
    logic wr_ack;
    logic vc0_pending;
    logic vc1_pending;
  } vcs_top_regs_t;

endpackage

// *** hdl/vcs_table_tracker.sv ***
/*
  Tracks the port arbitration table changed flag and sequences the copy of
  configuration-space table values into the working arbitration tables.
  Assumes one-cycle pulses from the configuration write decoder and from the
  arbitration engine that performs the copy.
*/
`timescale 1ns/10ps

module vcs_table_tracker (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic entry_wr, // Pulse, a table entry was modified
  input wire logic load_req, // Pulse, software wrote one to table-load
  input wire logic copy_done, // Pulse, the engine finished the copy
  output logic changed, // Table-changed flag
  output logic copy_req // Copy request to the arbitration engine
);

  vcs_pkg::vcs_tbl_regs_t cur_ff;
  vcs_pkg::vcs_tbl_regs_t nxt_cur;

  // Next-state logic
  always_comb begin
    nxt_cur = cur_ff;
    if (entry_wr) begin
      nxt_cur.changed = 1'b1;
    end
    unique case (cur_ff.state)
      vcs_pkg::VCS_TBL_IDLE: begin
        if (load_req) begin
          nxt_cur.state = vcs_pkg::VCS_TBL_LOAD;
          nxt_cur.copy_req = 1'b1;
          nxt_cur.dirty_in_load = 1'b0;
        end
      end
      vcs_pkg::VCS_TBL_LOAD: begin
        if (entry_wr) begin
          nxt_cur.dirty_in_load = 1'b1;
        end
        if (copy_done) begin
          nxt_cur.state = vcs_pkg::VCS_TBL_IDLE;
          nxt_cur.copy_req = 1'b0;
          // Clear only if no entry changed after the copy began; set wins
          if (!entry_wr && !cur_ff.dirty_in_load) begin
            nxt_cur.changed = 1'b0;
          end
        end
      end
      default: begin
        nxt_cur.state = vcs_pkg::VCS_TBL_IDLE;
        nxt_cur.copy_req = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '{state: vcs_pkg::VCS_TBL_IDLE, changed: 1'b0, dirty_in_load: 1'b0, copy_req: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops
  assign changed = cur_ff.changed;
  assign copy_req = cur_ff.copy_req;

endmodule // vcs_table_tracker

// *** hdl/vcs_regs.sv ***
/*
  VC0 resource status register and VC1 resource capability register.
  Assumes configuration accesses arrive as one-cycle read and write strobes
  with a byte offset into extended configuration space; negotiation and table
  events arrive as pulses or levels from the surrounding bridge logic.
*/
`timescale 1ns/10ps
`include "vcs_defines.svh"

module vcs_regs #(
  parameter int ADDR_W = `VCS_ADDR_W, // Configuration offset width
  parameter int DATA_W = `VCS_DATA_W // Configuration data width
) (
  input wire logic clk, // Core clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic cfg_rd, // Pulse, configuration read
  input wire logic cfg_wr, // Pulse, configuration write
  input wire logic [ADDR_W-1:0] cfg_addr, // Byte offset of the access
  input wire logic [DATA_W-1:0] cfg_wdata, // Write data, discarded here
  input wire logic vc0_neg_active, // Level, VC0 negotiation in progress
  input wire logic channel_enable_bit, // Pulse, software wrote one to VC1 enable
  input wire logic vc1_neg_done, // Pulse, VC1 negotiation finished
  input wire logic arb_entry_wr, // Pulse, VC1 table entry modified
  input wire logic table_load_wr, // Pulse, software wrote one to table-load
  input wire logic table_copy_done, // Pulse, copy into working tables done
  output logic [DATA_W-1:0] cfg_rdata, // Read data, valid with cfg_rd_valid
  output logic cfg_rd_valid, // Pulse, read answer
  output logic cfg_wr_ack, // Pulse, write accepted and dropped
  output logic vc_negotiation_pending, // VC0 pending flag
  output logic vc1_negotiation_pending, // VC1 pending flag
  output logic arb_table_changed, // Table-changed flag
  output logic table_copy_req // Copy request to arbitration engine
);

  vcs_pkg::vcs_top_regs_t cur_ff;
  vcs_pkg::vcs_top_regs_t nxt_cur;
  logic tbl_changed;
  logic tbl_copy_req;

  // Scheme support word, one bit per arbitration scheme
  function automatic logic [7:0] scheme_word(input logic fixed_rr, input logic tb_wrr128);
    logic [7:0] w;
    w = 8'h00;
    w[`VCS_SCH_FIXED_RR] = fixed_rr;
    w[`VCS_SCH_WRR32] = 1'b0;
    w[`VCS_SCH_WRR64] = 1'b0;
    w[`VCS_SCH_WRR128] = 1'b0;
    w[`VCS_SCH_TB_WRR128] = tb_wrr128;
    w[`VCS_SCH_WRR256] = 1'b0;
    return w;
  endfunction

  // Capability word assembled field by field
  function automatic logic [31:0] cap_word();
    logic [31:0] w;
    w = 32'h00000000;
    w[31:24] = `VCS_CAP_TBL_LOC;
    w[23] = 1'b0;
    w[22:16] = `VCS_CAP_SLOTS;
    w[15] = `VCS_CAP_SNOOP_REJ;
    w[14] = `VCS_CAP_AS_ONLY;
    w[13:8] = 6'h00;
    w[7:0] = scheme_word(1'b1, 1'b1);
    return w;
  endfunction

  // Status word from the live flags
  function automatic logic [15:0] status_word(input logic pend, input logic tbl);
    logic [15:0] w;
    w = `VCS_STAT_RESET;
    w[`VCS_STAT_PEND_BIT] = pend;
    w[`VCS_STAT_TBL_BIT] = tbl;
    return w;
  endfunction

  // Table changed flag and refresh sequencing
  vcs_table_tracker u_tbl (
    .clk(clk),
    .rst_n(rst_n),
    .entry_wr(arb_entry_wr),
    .load_req(table_load_wr),
    .copy_done(table_copy_done),
    .changed(tbl_changed),
    .copy_req(tbl_copy_req)
  );

  // Next-state logic: pending flags and configuration answers
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.vc0_pending = vc0_neg_active;
    if (channel_enable_bit) begin
      nxt_cur.vc1_pending = 1'b1;
    end else if (vc1_neg_done) begin
      nxt_cur.vc1_pending = 1'b0;
    end
    nxt_cur.rd_valid = cfg_rd;
    nxt_cur.wr_ack = cfg_wr;
    nxt_cur.rdata = `VCS_DATA_ZERO;
    // Reads only select data; no flag changes on a read
    if (cfg_rd) begin
      if (cfg_addr == `VCS_OFF_VC0_STATUS) begin
        nxt_cur.rdata = {16'h0000, status_word(cur_ff.vc0_pending, tbl_changed)};
      end else if (cfg_addr == `VCS_OFF_VC1_CAP) begin
        nxt_cur.rdata = cap_word();
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '{rdata: `VCS_DATA_ZERO, rd_valid: 1'b0, wr_ack: 1'b0, vc0_pending: 1'b0, vc1_pending: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops
  assign cfg_rdata = cur_ff.rdata;
  assign cfg_rd_valid = cur_ff.rd_valid;
  assign cfg_wr_ack = cur_ff.wr_ack;
  assign vc_negotiation_pending = cur_ff.vc0_pending;
  assign vc1_negotiation_pending = cur_ff.vc1_pending;
  assign arb_table_changed = tbl_changed;
  assign table_copy_req = tbl_copy_req;

endmodule // vcs_regs

// *** sim/vcs_regs_props.sv ***
/* Port checker for vcs_regs.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`include "vcs_defines.svh"
module vcs_regs_props #(parameter int ADDR_W = 12, parameter int DATA_W = 32) (
  input wire logic clk, // in
  input wire logic rst_n, // in
  input wire logic cfg_rd, // in
  input wire logic [ADDR_W-1:0] cfg_addr, // in
  input wire logic channel_enable_bit, // in
  input wire logic arb_entry_wr, // in
  input wire logic table_load_wr, // in
  input wire logic table_copy_done, // in
  input wire logic [DATA_W-1:0] cfg_rdata, // out
  input wire logic cfg_rd_valid, // out
  input wire logic vc_negotiation_pending, // out
  input wire logic vc1_negotiation_pending, // out
  input wire logic arb_table_changed, // out
  input wire logic table_copy_req // out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read requests per register
  sequence s_rd_stat; cfg_rd && cfg_addr == `VCS_OFF_VC0_STATUS; endsequence
  sequence s_rd_cap; cfg_rd && cfg_addr == `VCS_OFF_VC1_CAP; endsequence
  property p_stat_zero; s_rd_stat |=> cfg_rd_valid && cfg_rdata[31:2] == 30'h0; endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status high bits");
  property p_stat_flags; s_rd_stat |=> cfg_rdata[1:0] == $past({vc_negotiation_pending, arb_table_changed}); endproperty
  a_stat_flags: assert property (p_stat_flags) else $error("status flags");
  property p_cap; s_rd_cap |=> cfg_rd_valid && cfg_rdata == 32'h077f0011; endproperty
  a_cap: assert property (p_cap) else $error("capability");
  property p_set; arb_entry_wr |=> arb_table_changed; endproperty
  a_set: assert property (p_set) else $error("changed not set");
  property p_clr; $past(rst_n) && $fell(arb_table_changed) |-> $past(table_copy_done && table_copy_req); endproperty
  a_clr: assert property (p_clr) else $error("changed cleared early");
  property p_load; table_load_wr && !table_copy_req |=> table_copy_req; endproperty
  a_load: assert property (p_load) else $error("no copy request");
  property p_vc1; channel_enable_bit |=> vc1_negotiation_pending; endproperty
  a_vc1: assert property (p_vc1) else $error("vc1 pending");
  property p_quiet; !cfg_rd |=> !cfg_rd_valid && cfg_rdata == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("stray read data");
endmodule // vcs_regs_props
bind vcs_regs vcs_regs_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (.*);

// *** sim/vcs_arb_engine.sv ***
/* Copy engine model answering table refresh requests.
   Assumes the request level stays up until the done pulse. */
`timescale 1ns/10ps
module vcs_arb_engine (
  input wire logic clk, // Clock
  input wire logic [3:0] lat, // Cycles to done
  input wire logic copy_req, // Request
  output logic copy_done = 1'b0 // Done pulse
);
  logic [3:0] cnt = 4'h0;
  // Pulse done lat cycles into a request
  always @(posedge clk) begin
    copy_done <= copy_req && !copy_done && cnt == lat;
    cnt <= copy_req ? cnt + {3'h0, cnt != lat} : 4'h0;
  end
endmodule // vcs_arb_engine

// *** sim/vcs_regs_tb_top.sv ***
/* Self-checking bench for vcs_regs.
   Assumes the design files and the copy engine model are compiled first. */
`timescale 1ns/10ps
module vcs_regs_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, vc0_neg_active = 1'b0;
  logic channel_enable_bit = 1'b0, vc1_neg_done = 1'b0, arb_entry_wr = 1'b0, table_load_wr = 1'b0;
  logic table_copy_done, cfg_rd_valid, cfg_wr_ack, vc_negotiation_pending;
  logic vc1_negotiation_pending, arb_table_changed, table_copy_req;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [3:0] lat = 4'h3;
  int failures = 0, comparisons = 0;
  logic [11:0] row_addr [6] = '{12'h16a, 12'h16c, 12'h168, 12'h16b, 12'h170, 12'h000};
  logic [31:0] row_exp [6] = '{32'h0, 32'h077f0011, 32'h0, 32'h0, 32'h0, 32'h0};
  vcs_regs u_vcs_regs (.*);
  vcs_arb_engine u_vcs_arb_engine (.clk(clk), .lat(lat), .copy_req(table_copy_req), .copy_done(table_copy_done));
  always #25 clk = ~clk;
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict
  task end_sim;
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One config access, answer one cycle later
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] e);
    @(negedge clk);
    cfg_rd = ~wr;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_wdata = 32'hffffffff;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    chk("rdata", cfg_rdata, e);
    chk("answer", {31'h0, wr ? cfg_wr_ack : cfg_rd_valid}, 32'h1);
  endtask
  // One-cycle input pulse
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Bounded wait for the copy to end
  task wait_copy;
    int i;
    i = 0;
    while (table_copy_req !== 1'b0 && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (i == 20) begin
      failures++;
      end_sim;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk("idle", {26'h0, cfg_rd_valid, cfg_wr_ack, vc_negotiation_pending, vc1_negotiation_pending,
                 arb_table_changed, table_copy_req}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, row_addr[i], row_exp[i]);
    end
    acc(1'b1, 12'h16c, 32'h0);
    acc(1'b1, 12'h16a, 32'h0);
    acc(1'b0, 12'h16c, 32'h077f0011);
    vc0_neg_active = 1'b1;
    acc(1'b0, 12'h16a, 32'h2);
    vc0_neg_active = 1'b0;
    pulse(arb_entry_wr);
    acc(1'b0, 12'h16a, 32'h1);
    pulse(table_load_wr);
    wait_copy;
    chk("changed", {31'h0, arb_table_changed}, 32'h0);
    lat = 4'h6;
    pulse(arb_entry_wr);
    pulse(table_load_wr);
    pulse(arb_entry_wr);
    wait_copy;
    chk("kept", {31'h0, arb_table_changed}, 32'h1);
    lat = 4'h0;
    pulse(table_load_wr);
    wait_copy;
    chk("cleared", {31'h0, arb_table_changed}, 32'h0);
    pulse(channel_enable_bit);
    chk("vc1 set", {31'h0, vc1_negotiation_pending}, 32'h1);
    pulse(vc1_neg_done);
    chk("vc1 clr", {31'h0, vc1_negotiation_pending}, 32'h0);
    pulse(arb_entry_wr);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk("rst", {31'h0, arb_table_changed}, 32'h0);
    end_sim;
  end
endmodule // vcs_regs_tb_top
